// [bench/pin_timer_model.sv]
`timescale 1ns/1ps
module pin_timer_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        timer_hold,
  input  wire logic        timer_reset_req,
  input  wire logic [1:0]  ext,
  input  wire logic [1:0]  pad_out,
  input  wire logic [1:0]  pad_oe,
  output logic [15:0]      timer_count,
  output logic [1:0]       pad_in
);
  logic [1:0] tick_q;
  // Unit wins the pin while it drives, else the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
  // Synchronous timer, one tick in four clocks, never the raw clock
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_q      <= 2'h0;
      timer_count <= 16'h0000;
    end else if (load) begin
      timer_count <= load_val;
    end else if (timer_reset_req) begin
      timer_count <= 16'h0000;
    end else if (run && !timer_hold) begin
      tick_q <= tick_q + 2'h1;
      if (tick_q == 2'h3) begin
        timer_count <= timer_count + 16'h0001;
      end
    end
  end
endmodule

// [bench/tb_capture_compare_unit.sv]
`timescale 1ns/1ps
module tb_capture_compare_unit;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        err_q;
  logic        pready;
  logic        pslverr;
  logic        ext_clk = 1'b0;
  logic        sleep   = 1'b0;
  logic        adc_en  = 1'b1;
  logic        run     = 1'b0;
  logic        load    = 1'b0;
  logic        hold;
  logic        trq;
  logic        adc_st;
  logic        ev;
  logic [15:0] tcnt;
  logic [15:0] lval = 16'h0;
  logic [15:0] v;
  logic [1:0]  ext  = 2'h0;
  logic [1:0]  pout;
  logic [1:0]  poe;
  logic [1:0]  pin;
  logic [31:0] seed = 32'h040c;
  int          error_cnt = 0;
  int          compares  = 0;
  int          n_trq     = 0;
  int          n_adc     = 0;
  logic [3:0]  cm [6];

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_trq += int'(trq);
    n_adc += int'(adc_st);
  end

  capture_compare_unit DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_count(tcnt),
    .timer_ext_clk(ext_clk), .sleep(sleep), .timer_hold(hold),
    .timer_reset_req(trq), .adc_enabled(adc_en), .adc_start(adc_st),
    .unit_event_request(ev), .pad0_in(pin[0]), .pad0_out(pout[0]),
    .pad0_oe(poe[0]), .pad1_in(pin[1]), .pad1_out(pout[1]), .pad1_oe(poe[1]));
  pin_timer_model partner (.ref_clk(ref_clk), .reset(reset), .run(run),
    .load(load), .load_val(lval), .timer_hold(hold), .timer_reset_req(trq),
    .ext(ext), .pad_out(pout), .pad_oe(poe), .timer_count(tcnt), .pad_in(pin));

  ////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic int edges_for(input logic [3:0] m);
    if (m == ccu_pkg::MODE_CAP_RISE16) return 16;
    if (m == ccu_pkg::MODE_CAP_RISE4) return 4;
    return 1;
  endfunction
  // Latch starts low after each mode change
  function automatic logic exp_pin(input logic [3:0] m);
    return (m == ccu_pkg::MODE_CMP_CLEAR) ? 1'b0 : 1'b1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Idle cycle first, so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q     = prdata;
    err_q = pslverr;
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic pulse(input int p, input int k);
    repeat (k) begin
      ext[p] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext[p] <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  task automatic set_timer(input logic [15:0] val, input logic go);
    @(posedge ref_clk);
    load <= 1'b1;
    lval <= val;
    run  <= go;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask
  task automatic mode(input logic [3:0] m);
    wr(ccu_pkg::ADDR_UNIT_CONTROL, 8'h00);
    wr(ccu_pkg::ADDR_UNIT_CONTROL, {4'h0, m});
    wr(ccu_pkg::ADDR_FLAG, 8'h00);
  endtask
  task automatic cap_check(input int p, input logic [3:0] m);
    v = rnd();
    set_timer(v, 1'b0);
    wr(ccu_pkg::ADDR_FLAG, 8'h00);
    pulse(p, edges_for(m) - 1);
    rd("flag early", ccu_pkg::ADDR_FLAG, 0);
    pulse(p, 1);
    rd("flag", ccu_pkg::ADDR_FLAG, 1);
    rd("value low", ccu_pkg::ADDR_VALUE_LOW, {24'h0, v[7:0]});
    rd("value high", ccu_pkg::ADDR_VALUE_HIGH, {24'h0, v[15:8]});
  endtask
  task automatic wait_ev();
    int n;
    n = 0;
    while (ev !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////
  initial begin
    cm = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_TOGGLE, ccu_pkg::MODE_CMP_CLEAR,
           ccu_pkg::MODE_CMP_TOGGLE, ccu_pkg::MODE_CMP_SWINT, ccu_pkg::MODE_CMP_SPECIAL};
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd("control", ccu_pkg::ADDR_UNIT_CONTROL, 0);
    rd("value high", ccu_pkg::ADDR_VALUE_HIGH, 0);
    rd("enable", ccu_pkg::ADDR_ENABLE, 0);
    rd("pin config", ccu_pkg::ADDR_PIN_CONFIG, 1);
    rd("unmapped", 8'h18, 0);
    chk("slverr", 1, {31'h0, err_q});
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h01);
    for (int i = 4; i < 8; i++) begin
      mode(4'(i));
      cap_check(0, 4'(i));
    end
    mode(ccu_pkg::MODE_CAP_RISE4);
    pulse(0, 2);
    mode(ccu_pkg::MODE_CAP_RISE4);
    cap_check(0, ccu_pkg::MODE_CAP_RISE4);
    mode(ccu_pkg::MODE_CAP_RISE);
    cap_check(0, ccu_pkg::MODE_CAP_RISE);
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h05);
    wr(ccu_pkg::ADDR_FLAG, 8'h00);
    pulse(0, 1);
    rd("old pad", ccu_pkg::ADDR_FLAG, 0);
    cap_check(1, ccu_pkg::MODE_CAP_RISE);
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h04);
    @(negedge ref_clk);
    chk("pad oe", 2'h2, poe);
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h00);
    wr(ccu_pkg::ADDR_FLAG, 8'h00);
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h02);
    // Loopback passes two sync stages and the edge detect before the flag
    repeat (4) @(posedge ref_clk);
    rd("port capture", ccu_pkg::ADDR_FLAG, 1);
    sleep <= 1'b1;
    v = rnd();
    set_timer(v, 1'b1);
    repeat (20) @(negedge ref_clk);
    chk("timer held", v, tcnt);
    @(posedge ref_clk);
    sleep <= 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("resumed", 1, ((tcnt - v) >= 16'h2) && ((tcnt - v) <= 16'h3));
    @(posedge ref_clk);
    sleep   <= 1'b1;
    ext_clk <= 1'b1;
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h01);
    cap_check(0, ccu_pkg::MODE_CAP_RISE);
    sleep <= 1'b0;
    // Port latch high, so a mode that leaves the pin alone shows a one
    wr(ccu_pkg::ADDR_PIN_CONFIG, 8'h02);
    wr(ccu_pkg::ADDR_ENABLE, 8'h01);
    foreach (cm[i]) begin
      // Timer parked at zero, so a half-written value cannot match early
      set_timer(16'h0000, 1'b0);
      v = rnd() | 16'h8000;
      wr(ccu_pkg::ADDR_VALUE_LOW, v[7:0]);
      wr(ccu_pkg::ADDR_VALUE_HIGH, v[15:8]);
      mode(cm[i]);
      set_timer(v - 16'h0008, 1'b1);
      wr(ccu_pkg::ADDR_FLAG, 8'h00);
      wait_ev();
      if (i < 4) chk("pin", exp_pin(cm[i]), pout[0]);
      else chk("pin free", 1, pout[0]);
    end
    // Trigger pulse is counted at the edge after the flag rises
    repeat (2) @(negedge ref_clk);
    chk("trigger", 2, n_trq + n_adc);
    chk("timer cleared", 1, tcnt < 16'h0010);
    report_and_stop();
  end
endmodule

// [rtl/capture_compare_unit.sv]
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module capture_compare_unit (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Shared sixteen-bit timer
  input  wire logic [15:0] timer_count,
  input  wire logic        timer_ext_clk,
  input  wire logic        sleep,
  output logic             timer_hold,
  output logic             timer_reset_req,
  // Converter
  input  wire logic        adc_enabled,
  output logic             adc_start,
  // Event request to system interrupt logic
  output logic             unit_event_request,
  // Two candidate package pins
  input  wire logic        pad0_in,
  output logic             pad0_out,
  output logic             pad0_oe,
  input  wire logic        pad1_in,
  output logic             pad1_out,
  output logic             pad1_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  control_q;
  logic [7:0]  value_low_q;
  logic [7:0]  value_high_q;
  logic        flag_q;
  logic        enable_q;
  logic        pin_dir_q;
  logic        port_data_q;
  logic        alt_sel_q;
  logic        cmp_latch_q;
  logic        match_prev_q;
  logic        trigger_q;
  logic        adc_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire         setup_phase = psel & ~penable;
  wire         access_wr   = psel & penable & pwrite;
  wire         hit_control = (paddr == ccu_pkg::ADDR_UNIT_CONTROL);
  wire         hit_low     = (paddr == ccu_pkg::ADDR_VALUE_LOW);
  wire         hit_high    = (paddr == ccu_pkg::ADDR_VALUE_HIGH);
  wire         hit_flag    = (paddr == ccu_pkg::ADDR_FLAG);
  wire         hit_enable  = (paddr == ccu_pkg::ADDR_ENABLE);
  wire         hit_pin     = (paddr == ccu_pkg::ADDR_PIN_CONFIG);
  wire         mapped      = hit_control | hit_low | hit_high | hit_flag | hit_enable | hit_pin;
  wire         wr_control  = access_wr & hit_control;
  wire         wr_low      = access_wr & hit_low;
  wire         wr_high     = access_wr & hit_high;
  wire         wr_flag     = access_wr & hit_flag;
  wire         wr_enable   = access_wr & hit_enable;
  wire         wr_pin      = access_wr & hit_pin;
  wire [2:0]   pin_cfg     = {alt_sel_q, port_data_q, pin_dir_q};
  wire [31:0]  read_mux    = hit_control ? {24'h0, control_q}    :
                             hit_low     ? {24'h0, value_low_q}  :
                             hit_high    ? {24'h0, value_high_q} :
                             hit_flag    ? {31'h0, flag_q}       :
                             hit_enable  ? {31'h0, enable_q}     :
                             hit_pin     ? {29'h0, pin_cfg}      : 32'h0;

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // Read data captured in setup, so the answer comes from flip-flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q  <= pwrite ? 32'h0 : read_mux;
      pslverr_q <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  wire [3:0]   mode        = control_q[3:0];
  wire         cap_mode    = (mode[3:2] == 2'b01);
  wire         cap_fall    = (mode == ccu_pkg::MODE_CAP_FALL);
  wire         cap_rise    = (mode == ccu_pkg::MODE_CAP_RISE);
  wire         cap_rise4   = (mode == ccu_pkg::MODE_CAP_RISE4);
  wire         cap_rise16  = (mode == ccu_pkg::MODE_CAP_RISE16);
  wire         cmp_toggle  = (mode == ccu_pkg::MODE_CMP_TOGGLE);
  wire         cmp_set     = (mode == ccu_pkg::MODE_CMP_SET);
  wire         cmp_clear   = (mode == ccu_pkg::MODE_CMP_CLEAR);
  wire         cmp_swint   = (mode == ccu_pkg::MODE_CMP_SWINT);
  wire         cmp_special = (mode == ccu_pkg::MODE_CMP_SPECIAL);
  wire         cmp_drives  = cmp_toggle | cmp_set | cmp_clear;
  wire         cmp_mode    = cmp_drives | cmp_swint | cmp_special;

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing and capture path

  // Pad input buffer stays live while driving, so port writes loop back
  wire         pin_in_sel = alt_sel_q ? pad1_in : pad0_in;
  wire         pin_rise;
  wire         pin_fall;
  wire         presc_fire;
  wire [3:0]   presc_count;
  wire [3:0]   presc_last  = cap_rise16 ? ccu_pkg::PRESCALE_16_LAST :
                             cap_rise4  ? ccu_pkg::PRESCALE_4_LAST  : 4'h0;

  edge_sync u_edge_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (pin_in_sel),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  capture_prescaler u_capture_prescaler (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clear      (~cap_mode),
    .rise       (pin_rise & (cap_rise | cap_rise4 | cap_rise16)),
    .last_count (presc_last),
    .fire       (presc_fire),
    .count      (presc_count)
  );

  // No sleep gating: an externally clocked timer keeps captures alive
  wire         capture_fire = cap_mode & ((cap_fall & pin_fall) | presc_fire);

  ////////////////////////////////////////////////////////////////////////////
  // Compare path

  wire [15:0]  value     = {value_high_q, value_low_q};
  wire         match_now = cmp_mode & (value == timer_count);
  // Act once per match, not on every cycle the timer sits equal
  wire         cmp_act   = match_now & ~match_prev_q;
  wire         latch_d   = cmp_set    ? 1'b1 :
                           cmp_clear  ? 1'b0 :
                           cmp_toggle ? ~cmp_latch_q : cmp_latch_q;
  wire         flag_set  = capture_fire | cmp_act;
  // Hardware set wins over a software clear in the same cycle
  wire         flag_d    = flag_set ? 1'b1 : (wr_flag ? pwdata[ccu_pkg::FLAG_BIT] : flag_q);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      control_q    <= ccu_pkg::CONTROL_RESET;
      enable_q     <= 1'b0;
      pin_dir_q    <= ccu_pkg::PIN_DIR_RESET;
      port_data_q  <= 1'b0;
      alt_sel_q    <= ccu_pkg::ALT_SEL_RESET;
      flag_q       <= 1'b0;
      match_prev_q <= 1'b0;
    end else begin
      if (wr_control) begin
        control_q <= pwdata[7:0];
      end
      if (wr_enable) begin
        enable_q <= pwdata[0];
      end
      if (wr_pin) begin
        pin_dir_q   <= pwdata[ccu_pkg::PIN_DIR_BIT];
        port_data_q <= pwdata[ccu_pkg::PORT_BIT];
        alt_sel_q   <= pwdata[ccu_pkg::ALT_SEL_BIT];
      end
      flag_q       <= flag_d;
      match_prev_q <= match_now;
    end
  end

  // Capture beats a software write to the value pair
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      value_low_q  <= ccu_pkg::VALUE_RESET;
      value_high_q <= ccu_pkg::VALUE_RESET;
    end else if (capture_fire) begin
      value_low_q  <= timer_count[7:0];
      value_high_q <= timer_count[15:8];
    end else begin
      if (wr_low) begin
        value_low_q <= pwdata[7:0];
      end
      if (wr_high) begin
        value_high_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmp_latch_q <= 1'b0;
      trigger_q   <= 1'b0;
      adc_q       <= 1'b0;
    end else begin
      if (wr_control && pwdata[7:0] == 8'h00) begin
        cmp_latch_q <= 1'b0;
      end else if (cmp_act) begin
        cmp_latch_q <= latch_d;
      end
      trigger_q <= cmp_act & cmp_special;
      adc_q     <= cmp_act & cmp_special & adc_enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Software interrupt and special trigger modes leave the port latch on the pin
  wire         pin_level = cmp_drives ? cmp_latch_q : port_data_q;

  assign pad0_out           = ~alt_sel_q & pin_level;
  assign pad0_oe            = ~alt_sel_q & ~pin_dir_q;
  assign pad1_out           = alt_sel_q & pin_level;
  assign pad1_oe            = alt_sel_q & ~pin_dir_q;
  assign timer_reset_req    = trigger_q;
  assign adc_start          = adc_q;
  assign timer_hold         = sleep & ~timer_ext_clk;
  // Masking only here; a false flag from a mode change stays for software
  assign unit_event_request = flag_q & enable_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_capture_value: assert property (@(posedge ref_clk) disable iff (reset)
    capture_fire |=> value == $past(timer_count))
    else $error("capture did not store timer count");

  a_capture_flag: assert property (@(posedge ref_clk) disable iff (reset)
    capture_fire |=> flag_q)
    else $error("capture did not set event flag");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    flag_q && !wr_flag |=> flag_q)
    else $error("event flag cleared without software");

  a_presc_cleared: assert property (@(posedge ref_clk) disable iff (reset)
    !cap_mode |=> presc_count == 4'h0)
    else $error("prescaler not cleared outside capture");

  // A direct switch from divide by sixteen may leave the count above three
  a_every_fourth: assert property (@(posedge ref_clk) disable iff (reset)
    cap_rise4 && presc_fire |-> presc_count >= ccu_pkg::PRESCALE_4_LAST
    ##1 presc_count == 4'h0)
    else $error("divide by four fired at wrong count");

  a_match_flag: assert property (@(posedge ref_clk) disable iff (reset)
    cmp_act && !wr_control |=> flag_q && (cmp_drives ? cmp_latch_q == $past(latch_d) : 1'b1))
    else $error("match action and flag not together");

  a_toggle_flip: assert property (@(posedge ref_clk) disable iff (reset)
    cmp_act && cmp_toggle && !wr_control |=> cmp_latch_q != $past(cmp_latch_q))
    else $error("toggle mode did not flip latch");

  a_special_trig: assert property (@(posedge ref_clk) disable iff (reset)
    cmp_act && cmp_special |=> timer_reset_req && (adc_start == $past(adc_enabled)) ##1
    !timer_reset_req)
    else $error("special trigger pulse wrong");

  a_swint_pin: assert property (@(posedge ref_clk) disable iff (reset)
    cmp_swint |-> pin_level == port_data_q)
    else $error("software interrupt mode drove the pin");

  a_zero_low: assert property (@(posedge ref_clk) disable iff (reset)
    wr_control && pwdata[7:0] == 8'h00 |=> !cmp_latch_q)
    else $error("clearing control left latch high");

  a_one_edge: assert property (@(posedge ref_clk) disable iff (reset)
    capture_fire |=> !capture_fire)
    else $error("one edge gave two captures");

  a_alt_route: assert property (@(posedge ref_clk) disable iff (reset)
    alt_sel_q |-> !pad0_oe && !pad0_out)
    else $error("default pin driven while rerouted");

  a_timer_hold: assert property (@(posedge ref_clk) disable iff (reset)
    sleep && !timer_ext_clk |-> timer_hold)
    else $error("timer not held in sleep");

  a_fall_capture: assert property (@(posedge ref_clk) disable iff (reset)
    cap_fall && pin_fall |-> capture_fire)
    else $error("falling edge gave no capture");

  a_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
    flag_set && wr_flag |=> flag_q)
    else $error("software clear beat a hardware set");

  a_presc_keep: assert property (@(posedge ref_clk) disable iff (reset)
    cap_mode && !pin_rise |=> presc_count == $past(presc_count))
    else $error("prescaler count lost inside capture");

  a_match_sets: assert property (@(posedge ref_clk) disable iff (reset)
    cmp_mode && value == timer_count && !match_prev_q |=> flag_q)
    else $error("equal count raised no flag");

  a_special_pin: assert property (@(posedge ref_clk) disable iff (reset)
    cmp_special |-> pin_level == port_data_q)
    else $error("special trigger mode drove the pin");

  a_adc_with_trig: assert property (@(posedge ref_clk) disable iff (reset)
    adc_start |-> timer_reset_req)
    else $error("conversion start without timer reset");

endmodule

// [rtl/capture_prescaler.sv]
`timescale 1ns/1ps
module capture_prescaler (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       rise,
  input  wire logic [3:0] last_count,
  output logic            fire,
  output logic [3:0]      count
);

  logic [3:0] count_q;
  logic [3:0] count_d;
  logic       wrap;

  assign wrap    = (count_q >= last_count);
  assign fire    = rise & wrap;
  assign count_d = clear ? 4'h0 : (rise ? (wrap ? 4'h0 : 4'(count_q + 4'h1)) : count_q);
  assign count   = count_q;

  // Count survives a change of divisor; wrap test uses >= for that case
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// [rtl/ccu_pkg.sv]
package ccu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_VALUE_LOW    = 8'h04;
  localparam logic [7:0] ADDR_VALUE_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_FLAG         = 8'h0c;
  localparam logic [7:0] ADDR_ENABLE       = 8'h10;
  localparam logic [7:0] ADDR_PIN_CONFIG   = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FLAG_BIT    = 0;
  localparam int PIN_DIR_BIT = 0;
  localparam int PORT_BIT    = 1;
  localparam int ALT_SEL_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] VALUE_RESET    = 8'h00;
  localparam logic       PIN_DIR_RESET  = 1'b1;
  localparam logic       ALT_SEL_RESET  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Mode codes of unit_mode_select
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SWINT  = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler counts
  localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

endpackage

// [rtl/edge_sync.sv]
`timescale 1ns/1ps
module edge_sync (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule
